// file: wakeup_tick_pkg.sv
// Purpose: Shared constants and types for the wake-up tick timer.
// Assumes: 32-bit APB register bus, 100 MHz system clock.
// Notes:   All register offsets are byte addresses on aligned words.

package wakeup_tick_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] ADDR_VALUE  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_EXTENDED_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_IRQ_EN_BIT = 1;
  localparam int CFG_FLAG_BIT   = 2;
  localparam int CFG_SSTEP_BIT  = 3;
  localparam int EXTENDED_CONFIG_OVS_BIT   = 5;
  localparam int STAT_OVF_BIT   = 0;

  // ********************************************************************
  // Reset values and timing
  // ********************************************************************
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_STEP   = 8'h01;
  localparam int         SYNC_DELAY   = 3;
  localparam logic       MASK_RESET   = 1'b1;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0]            count;
    logic                  enable;
    logic                  irq_enable;
    logic                  flag;
    logic                  single_step;
    logic                  oversample;
    logic                  mask;
    logic [1:0]            ext_sync;
    logic                  ext_prev;
    logic [SYNC_DELAY-1:0] ovf_delay;
    logic [31:0]           prdata;
    logic                  pslverr;
  } timer_state_t;

endpackage

// file: wakeup_tick_timer.sv
// Purpose: Wake-up tick timer with APB registers and overflow interrupt.
// Assumes: External tick clock much slower than clk; sampled here.
// Notes:   APB answers with zero wait states; read data is registered.
//
// Overview of operation
// R1: Eight-bit up-counter producing a periodic interrupt able to wake system.
// R2: Counter keeps running and interrupting independent of CPU activity.
// R3: Counter interrupt is a wake request ending oscillator-off low power.
// R4: Wrap FF to 00 sets flag; interrupt needs irq enable and enable.
// R5: Software clears enable or irq enable first, then the flag.
// R6: Flag still set after disabling stays pending as a new interrupt.
// R7: CPU can read and write the counter value register.
// R8: Extended config bit 5 selects oversampling of the external clock.
// R9: System clock must be at least twice the external clock.
// R10: Software clears oversample select before stopping the system clock.
// R11: Oversampling off: external input clocks counter, sync or async; here it is sampled by clk in both modes.
// R12: Oversampling off: overflow interrupt delayed three system clock cycles.
// R13: Oversampling off: counter reads unreliable unless clocks are synchronous.
// R14: Software sets oversample select before reading with asynchronous clocks.
// R15: Software toggles oversample select with each system clock source change.
// R16: Software keeps single-step control cleared during single-step debugging.
// R17: Flag write clears it; counter write loads without spurious overflow.
//
// Decided for this implementation: the placing of the registers and the APB register port.

`timescale 1ns/1ps

module wakeup_tick_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wake_ext_clock,
  output logic             wake_irq,
  output logic             wake_request,
  output logic             wake_pending
);

  // ********************************************************************
  // State
  // ********************************************************************
  wakeup_tick_pkg::timer_state_t    cur;
  wakeup_tick_pkg::timer_state_t    next_cur;
  wakeup_tick_pkg::apb_req_t        req;
  logic                             tick;
  logic                             wrap;
  logic                             wr_access;
  logic                             rd_setup;
  logic                             flag_set;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == wakeup_tick_pkg::ADDR_VALUE)  ||
             (a == wakeup_tick_pkg::ADDR_CONFIG) ||
             (a == wakeup_tick_pkg::ADDR_EXTENDED_CONFIG)   ||
             (a == wakeup_tick_pkg::ADDR_STATUS) ||
             (a == wakeup_tick_pkg::ADDR_MASK);
  endfunction

  function automatic logic [31:0] read_word(
    input wakeup_tick_pkg::timer_state_t s,
    input logic [7:0]                   a
  );
    read_word = 32'h0000_0000;
    case (a)
      wakeup_tick_pkg::ADDR_VALUE:
      begin
        read_word[7:0] = s.count;
      end
      wakeup_tick_pkg::ADDR_CONFIG:
      begin
        read_word[wakeup_tick_pkg::CFG_ENABLE_BIT] = s.enable;
        read_word[wakeup_tick_pkg::CFG_IRQ_EN_BIT] = s.irq_enable;
        read_word[wakeup_tick_pkg::CFG_FLAG_BIT]   = s.flag;
        read_word[wakeup_tick_pkg::CFG_SSTEP_BIT]  = s.single_step;
      end
      wakeup_tick_pkg::ADDR_EXTENDED_CONFIG:
      begin
        read_word[wakeup_tick_pkg::EXTENDED_CONFIG_OVS_BIT] = s.oversample;
      end
      wakeup_tick_pkg::ADDR_STATUS:
      begin
        read_word[wakeup_tick_pkg::STAT_OVF_BIT] = s.flag;
      end
      wakeup_tick_pkg::ADDR_MASK:
      begin
        read_word[wakeup_tick_pkg::STAT_OVF_BIT] = s.mask;
      end
      default:
      begin
        read_word = 32'h0000_0000;
      end
    endcase
  endfunction

  function automatic logic is_write(
    input wakeup_tick_pkg::apb_req_t r,
    input logic [7:0]                a
  );
    is_write = r.psel && r.penable && r.pwrite && (r.paddr == a);
  endfunction

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  always_comb
  begin
    req.psel    = psel;
    req.penable = penable;
    req.pwrite  = pwrite;
    req.paddr   = paddr;
    req.pwdata  = pwdata;
  end

  assign wr_access = req.psel && req.penable && req.pwrite;
  assign rd_setup  = req.psel && !req.penable;

  // The external clock is only ever seen through two flip-flops, so both
  // modes count the same edges; the direct mode keeps its delayed flag.
  assign tick = cur.ext_sync[1] && !cur.ext_prev;   // [R11]
  assign wrap = tick && cur.enable &&
                (cur.count == wakeup_tick_pkg::COUNT_MAX);   // [R4]

  // Oversampled wraps flag at once; direct wraps pass the sync delay.
  assign flag_set = cur.oversample ? wrap :
                    cur.ovf_delay[wakeup_tick_pkg::SYNC_DELAY-1];   // [R8] [R12]

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    next_cur = cur;
    next_cur.ext_sync = {cur.ext_sync[0], wake_ext_clock};
    next_cur.ext_prev = cur.ext_sync[1];
    next_cur.ovf_delay = {cur.ovf_delay[wakeup_tick_pkg::SYNC_DELAY-2:0],
                          wrap && !cur.oversample};   // [R12]
    next_cur.pslverr = 1'b0;
    if (rd_setup)
    begin
      next_cur.prdata  = read_word(cur, req.paddr);
      next_cur.pslverr = !mapped(req.paddr);
    end
    // Counting runs on its own; bus activity never stalls it.
    if (tick && cur.enable)
    begin
      next_cur.count = cur.count + wakeup_tick_pkg::COUNT_STEP;   // [R1] [R2]
    end
    if (wr_access)
    begin
      case (req.paddr)
        wakeup_tick_pkg::ADDR_VALUE:
        begin
          // A load only changes the value; overflow comes from wraps alone.
          next_cur.count = req.pwdata[7:0];   // [R7] [R17]
        end
        wakeup_tick_pkg::ADDR_CONFIG:
        begin
          next_cur.enable      = req.pwdata[wakeup_tick_pkg::CFG_ENABLE_BIT];
          next_cur.irq_enable  = req.pwdata[wakeup_tick_pkg::CFG_IRQ_EN_BIT];
          next_cur.single_step = req.pwdata[wakeup_tick_pkg::CFG_SSTEP_BIT];
          if (req.pwdata[wakeup_tick_pkg::CFG_FLAG_BIT])
          begin
            next_cur.flag = 1'b0;   // [R17]
          end
        end
        wakeup_tick_pkg::ADDR_EXTENDED_CONFIG:
        begin
          next_cur.oversample = req.pwdata[wakeup_tick_pkg::EXTENDED_CONFIG_OVS_BIT]; // [R8]
        end
        wakeup_tick_pkg::ADDR_STATUS:
        begin
          if (req.pwdata[wakeup_tick_pkg::STAT_OVF_BIT])
          begin
            next_cur.flag = 1'b0;   // [R17]
          end
        end
        wakeup_tick_pkg::ADDR_MASK:
        begin
          next_cur.mask = req.pwdata[wakeup_tick_pkg::STAT_OVF_BIT];
        end
        default:
        begin
          next_cur.mask = cur.mask;
        end
      endcase
    end
    // A flag_set in the same cycle as a clear keeps the flag set.
    if (flag_set)
    begin
      next_cur.flag = 1'b1;   // [R4]
    end
    if (rst)
    begin
      next_cur.count       = wakeup_tick_pkg::COUNT_RESET;
      next_cur.enable      = 1'b0;
      next_cur.irq_enable  = 1'b0;
      next_cur.flag        = 1'b0;
      next_cur.single_step = 1'b0;
      next_cur.oversample  = 1'b0;
      next_cur.mask        = wakeup_tick_pkg::MASK_RESET;
      next_cur.ext_sync    = '0;
      next_cur.ext_prev    = 1'b0;
      next_cur.ovf_delay   = '0;
      next_cur.prdata      = 32'h0000_0000;
      next_cur.pslverr     = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    cur <= next_cur;
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign pready  = req.psel && req.penable;
  assign prdata  = cur.prdata;
  assign pslverr = cur.pslverr && pready;

  // The flag stays pending while set, so clearing only an enable brings
  // the interrupt back as soon as software enables it again.
  assign wake_pending = cur.flag;   // [R6]
  assign wake_irq     = cur.flag && cur.irq_enable &&
                        cur.enable && cur.mask;   // [R4] [R6]
  assign wake_request = wake_irq;   // [R3]

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The flag may only rise through flag_set, so a counter load can never
  // pass for an overflow; several checks below lean on that.

  chk_wrap_to_zero: assert property (   // [R1]
    wrap && !(wr_access && req.paddr == wakeup_tick_pkg::ADDR_VALUE)
    |=> cur.count == wakeup_tick_pkg::COUNT_RESET)
    else $error("counter did not wrap to zero");

  chk_count_step: assert property (   // [R2]
    tick && cur.enable && !wr_access
    |=> cur.count == $past(cur.count) + wakeup_tick_pkg::COUNT_STEP)
    else $error("counter did not step on tick");

  chk_irq_gating: assert property (   // [R4]
    wake_irq |-> cur.flag && cur.irq_enable && cur.enable)
    else $error("interrupt raised without enables");

  chk_wake_follows: assert property (   // [R3]
    wake_request == wake_irq)
    else $error("wake request differs from interrupt");

  chk_direct_delay: assert property (   // [R12]
    wrap && !cur.oversample ##1 !cur.oversample [*3]
    |=> cur.flag)
    else $error("direct mode flag not set after three cycles");

  chk_ovs_flag: assert property (   // [R8]
    wrap && cur.oversample |=> cur.flag)
    else $error("oversampled wrap did not set flag");

  chk_pending_stays: assert property (   // [R6]
    cur.flag && !flag_set && !wr_access |=> cur.flag)
    else $error("pending flag lost without clear");

  chk_counter_load: assert property (   // [R7]
    wr_access && req.paddr == wakeup_tick_pkg::ADDR_VALUE
    |=> cur.count == $past(req.pwdata[7:0]))
    else $error("counter write not loaded");

  chk_no_spurious: assert property (   // [R17]
    is_write(req, wakeup_tick_pkg::ADDR_VALUE) && !cur.flag && !flag_set
    |=> !cur.flag)
    else $error("counter load raised the flag");

  chk_set_wins: assert property (   // [R17]
    flag_set |=> cur.flag)
    else $error("flag clear beat a set");

  chk_flag_source: assert property (   // [R17]
    !cur.flag && !flag_set |=> !cur.flag)
    else $error("flag rose without a counted wrap");

  chk_status_clear: assert property (   // [R17]
    is_write(req, wakeup_tick_pkg::ADDR_STATUS) && !flag_set &&
    req.pwdata[wakeup_tick_pkg::STAT_OVF_BIT]
    |=> !cur.flag)
    else $error("status write of one did not clear flag");

  chk_count_hold: assert property (   // [R11]
    !tick && !wr_access |=> $stable(cur.count))
    else $error("counter moved without an external edge");

  chk_disabled_hold: assert property (   // [R4]
    !cur.enable && !wr_access |=> $stable(cur.count))
    else $error("disabled counter moved");

  chk_mask_gate: assert property (   // [R4]
    !cur.mask |-> !wake_irq)
    else $error("masked flag raised interrupt");

  chk_direct_early: assert property (   // [R12]
    wrap && !cur.oversample && !cur.flag && !flag_set |=> !cur.flag)
    else $error("direct mode flag set without delay");

  chk_disabled_pending: assert property (   // [R6]
    cur.flag && !(cur.irq_enable && cur.enable)
    |-> wake_pending && !wake_irq)
    else $error("disabled flag not held pending");

  chk_value_read: assert property (   // [R7]
    rd_setup && req.paddr == wakeup_tick_pkg::ADDR_VALUE
    |=> prdata[7:0] == $past(cur.count))
    else $error("counter read returned wrong value");

  chk_ovs_write: assert property (   // [R8]
    is_write(req, wakeup_tick_pkg::ADDR_EXTENDED_CONFIG)
    |=> cur.oversample ==
        $past(req.pwdata[wakeup_tick_pkg::EXTENDED_CONFIG_OVS_BIT]))
    else $error("oversample select not stored");

  chk_enable_write: assert property (   // [R4]
    is_write(req, wakeup_tick_pkg::ADDR_CONFIG)
    |=> cur.enable ==
        $past(req.pwdata[wakeup_tick_pkg::CFG_ENABLE_BIT]) &&
        cur.irq_enable ==
        $past(req.pwdata[wakeup_tick_pkg::CFG_IRQ_EN_BIT]))
    else $error("enable bits not stored");

  cov_irq_raised: cover property (!wake_irq ##1 wake_irq);
  cov_direct_wrap: cover property (wrap && !cur.oversample);
  cov_ovs_wrap: cover property (wrap && cur.oversample);
  cov_counter_load: cover property (
    wr_access && req.paddr == wakeup_tick_pkg::ADDR_VALUE);
  cov_flag_cleared: cover property (
    cur.flag ##1 !cur.flag);

endmodule

// file: ext_tick_source.sv
// Purpose: Model of the external real-time tick source.
// Assumes: The bench asks for one burst at a time.
// Notes:   The line rests low between bursts.
`timescale 1ns/1ps
module ext_tick_source (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            tick,
  output logic            busy
);
  // A 3 ns offset keeps the edges off the clk edges.
  initial
  begin
    tick = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk iff go);
      busy = 1'b1;
      #3;
      repeat (pulses)
      begin
        tick = 1'b1;
        #40;
        tick = 1'b0;
        #40;
      end
      busy = 1'b0;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the wake-up tick timer.
// Assumes: Zero-wait APB slave; tick source model on the external clock input.
// Notes:   Random-test loads after the first three and burst lengths come from an LFSR with a fixed seed.
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, psel, penable, pwrite, go, tick, busy;
  logic        pready, pslverr, irq, wreq, pend, err;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pulses;
  logic [15:0] lf;
  logic [8:0]  e;
  int          mismatches, total_checks, cycles, lat[2];

  wakeup_tick_timer i_wakeup_tick_timer (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_ext_clock(tick), .wake_irq(irq),
    .wake_request(wreq), .wake_pending(pend));
  ext_tick_source i_ext_tick_source (
    .clk(clk), .go(go), .pulses(pulses), .tick(tick), .busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // The ninth bit tells whether the count wrapped through zero.
  function automatic logic [8:0] count_after(input logic [7:0] s,
                                             input int n);
    return {1'b0, s} + 9'(n);
  endfunction

  function automatic logic [31:0] cfg(input logic en, input logic ie);
    return (32'(en) << wakeup_tick_pkg::CFG_ENABLE_BIT) |
           (32'(ie) << wakeup_tick_pkg::CFG_IRQ_EN_BIT);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] x);
    total_checks++;
    if (seen !== x)
    begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(rd, x);
    check(32'(err), 32'h0);
  endtask

  task automatic burst(input logic [3:0] n);
    pulses <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy)
      @(posedge clk);
    @(posedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    {rst, psel, penable, pwrite, go} = 5'h10;
    {paddr, pwdata, pulses} = '0;
    lf = 16'h7779;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(wakeup_tick_pkg::ADDR_VALUE, 32'h0);
    rdchk(wakeup_tick_pkg::ADDR_CONFIG, 32'h0);
    rdchk(wakeup_tick_pkg::ADDR_EXTENDED_CONFIG, 32'h0);
    rdchk(wakeup_tick_pkg::ADDR_MASK,
          32'(wakeup_tick_pkg::MASK_RESET));
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    wr(wakeup_tick_pkg::ADDR_EXTENDED_CONFIG, 32'h20);
    rdchk(wakeup_tick_pkg::ADDR_EXTENDED_CONFIG, 32'h20);
    wr(wakeup_tick_pkg::ADDR_CONFIG, 32'h8);
    rdchk(wakeup_tick_pkg::ADDR_CONFIG, 32'h8);
    $display("test registers done");
    wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b1));
    for (int i = 0; i < 12; i++)
    begin
      lf = nxt(lf);
      v = (i < 3) ? 8'hFF - 8'(i) : lf[7:0];
      wr(wakeup_tick_pkg::ADDR_EXTENDED_CONFIG, 32'(lf[11]) << 5);
      wr(wakeup_tick_pkg::ADDR_VALUE, 32'(v));
      @(negedge clk);
      check(32'(pend), 32'h0);
      e = count_after(v, 1 + lf[10:8]);
      burst(4'(1 + lf[10:8]));
      rdchk(wakeup_tick_pkg::ADDR_VALUE, 32'(e[7:0]));
      check(32'(pend), 32'(e[8]));
      check(32'(irq), 32'(e[8]));
      check(32'(wreq), 32'(e[8]));
      wr(wakeup_tick_pkg::ADDR_STATUS, 32'h1);
    end
    $display("test random counting done");
    for (int m = 0; m < 2; m++)
    begin
      wr(wakeup_tick_pkg::ADDR_EXTENDED_CONFIG, 32'(m) << 5);
      wr(wakeup_tick_pkg::ADDR_VALUE, 32'hFF);
      wr(wakeup_tick_pkg::ADDR_STATUS, 32'h1);
      pulses <= 4'h1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge tick);
      lat[m] = 0;
      while (pend !== 1'b1 && lat[m] < 50)
      begin
        @(posedge clk);
        lat[m]++;
      end
      while (busy)
        @(posedge clk);
    end
    check(32'(lat[0] - lat[1]), 32'(wakeup_tick_pkg::SYNC_DELAY));
    rdchk(wakeup_tick_pkg::ADDR_STATUS, 32'h1);
    rdchk(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b1) | 32'h4);
    $display("test overflow delay done");
    for (int k = 0; k < 4; k++)
    begin
      wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(k[0], k[1]));
      @(negedge clk);
      check(32'(irq), 32'(k == 3));
      check(32'(wreq), 32'(k == 3));
    end
    wr(wakeup_tick_pkg::ADDR_MASK, 32'h0);
    @(negedge clk);
    check(32'(irq), 32'h0);
    wr(wakeup_tick_pkg::ADDR_MASK, 32'h1);
    wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b0));
    @(negedge clk);
    check(32'(irq), 32'h0);
    check(32'(pend), 32'h1);
    wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b1));
    @(negedge clk);
    check(32'(irq), 32'h1);
    wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b0));
    wr(wakeup_tick_pkg::ADDR_CONFIG, cfg(1'b1, 1'b0) | 32'h4);
    @(negedge clk);
    check(32'(pend), 32'h0);
    $display("test irq gating done");
    wr(wakeup_tick_pkg::ADDR_CONFIG, 32'h0);
    wr(wakeup_tick_pkg::ADDR_VALUE, 32'h0A);
    burst(4'h3);
    rdchk(wakeup_tick_pkg::ADDR_VALUE, 32'h0A);
    $display("test disabled counter done");
    final_report();
  end
endmodule
